// >>> pkg/speep_pkg.sv
// Constants, opcodes and status layout for the serial memory command port.
// Assumes a single core clock of 250 MHz; all pins are sampled in that domain.
package speep_pkg;
  // Opcodes with the density bit X held at zero
  localparam logic [7:0] SPEEP_OP_SET_PERMIT   = 8'h06;
  localparam logic [7:0] SPEEP_OP_CLEAR_PERMIT = 8'h04;
  localparam logic [7:0] SPEEP_OP_READ_STATUS  = 8'h05;
  localparam logic [7:0] SPEEP_OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] SPEEP_OP_READ_MEM     = 8'h03;
  localparam logic [7:0] SPEEP_OP_WRITE_MEM    = 8'h02;
  localparam logic [7:0] SPEEP_OP_XBIT_MASK    = 8'hF7;
  localparam int         SPEEP_OP_XBIT_POS     = 3;
  // Status byte layout
  localparam int         SPEEP_ST_BUSY_POS     = 0;
  localparam int         SPEEP_ST_LATCH_POS    = 1;
  localparam int         SPEEP_ST_GUARD_LO_POS = 2;
  localparam int         SPEEP_ST_GUARD_HI_POS = 3;
  localparam logic [3:0] SPEEP_ST_TOP_ONES     = 4'hF;
  localparam logic [1:0] SPEEP_GUARD_RESET     = 2'h0;
  // Page and timing
  localparam int         SPEEP_PAGE_BYTES      = 16;
  localparam int         SPEEP_CLK_MHZ         = 250;
  localparam int         SPEEP_WRITE_TIME_MS   = 5;
  localparam int         SPEEP_WRITE_CYCLES    = SPEEP_WRITE_TIME_MS * 1000 * SPEEP_CLK_MHZ;
  // Transaction phases
  typedef enum logic [2:0] {
    SPEEP_PH_OPCODE,
    SPEEP_PH_ADDR,
    SPEEP_PH_RDATA,
    SPEEP_PH_WDATA,
    SPEEP_PH_STATUS_OUT,
    SPEEP_PH_STATUS_IN,
    SPEEP_PH_IGNORE
  } speep_phase_t;
endpackage : speep_pkg

// >>> logic/speep_sync.sv
// Two-flop synchroniser for a group of pin levels.
// Assumes inputs are asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module speep_sync
  import speep_pkg::*;
#(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  // First stage feeds only the second
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      stage_one <= INIT;
      sync_out  <= INIT;
    end
    else
    begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end
endmodule : speep_sync
`default_nettype wire

// >>> logic/speep_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; read data is the head entry, read out without a register.
`timescale 1ns/1ps
`default_nettype none
module speep_fifo
  import speep_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = store[rd_ptr];

  // Storage write
  always_ff @(posedge core_clk)
  begin
    if (push)
      store[wr_ptr] <= in_data;
  end

  // Pointers and fill count
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Count never passes the depth
  fifo_bound_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    count <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule : speep_fifo
`default_nettype wire

// >>> logic/speep_top.sv
// Serial command port of a byte-wide non-volatile memory, device side.
// Assumes the host drives select, shift clock, data-in, pause and guard pins
// asynchronously; all are sampled on core_clk. Array storage is flip-flops.
`timescale 1ns/1ps
`default_nettype none
module speep_top
  import speep_pkg::*;
#(
  parameter int ADDR_BITS    = 9,
  parameter int WRITE_CYCLES = SPEEP_WRITE_CYCLES,
  parameter int FIFO_DEPTH   = SPEEP_PAGE_BYTES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // Serial link pins
  input  wire logic select_b,
  input  wire logic shift_clk,
  input  wire logic data_in,
  input  wire logic pause_b,
  input  wire logic write_guard_b,
  output logic      data_out,
  output logic      data_out_oe,
  // Stored protect bits, restored from and saved to non-volatile storage, and the programming busy flag
  input  wire logic [1:0] guard_restore,
  output logic      [1:0] guard_level,
  output logic      busy
);
  localparam int MEM_BYTES = 1 << ADDR_BITS;
  localparam int CW        = $clog2(WRITE_CYCLES + 1);
  localparam int PW        = $clog2(SPEEP_PAGE_BYTES);

  // ----------------------------------------------------------------------
  // Pin sampling and edge detection
  // ----------------------------------------------------------------------
  logic [3:0] pins_s;
  logic       sck_d;
  logic       sel_d;
  speep_sync #(.WIDTH(4), .INIT(4'hC)) u_sync (   // Idle: deselected, not paused
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .async_in ({select_b, pause_b, shift_clk, data_in}),
    .sync_out (pins_s)
  );
  wire sel_s   = pins_s[3];
  wire pause_s = pins_s[2];
  wire sck_s   = pins_s[1];
  wire din_s   = pins_s[0];
  wire active  = !sel_s && pause_s;
  wire sck_rise = active && sck_s && !sck_d;
  wire sck_fall = active && !sck_s && sck_d;
  wire sel_open  = !sel_s && sel_d;
  wire sel_close = sel_s && !sel_d;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      sck_d <= 1'b0;
      sel_d <= 1'b1;
    end
    else
    begin
      sck_d <= sck_s;
      sel_d <= sel_s;
    end
  end

  // ----------------------------------------------------------------------
  // Shift state
  // ----------------------------------------------------------------------
  speep_phase_t         phase;
  logic [7:0]           shift_in;
  logic [2:0]           bit_cnt;
  logic [7:0]           opcode;
  logic [ADDR_BITS-1:0] addr;
  logic [7:0]           tx_byte;
  logic [7:0]           mem [MEM_BYTES];
  logic                 permit;
  logic [1:0]           new_guard;
  logic                 status_pending;
  logic                 page_pending;
  logic [ADDR_BITS-1:0] page_base;
  logic [PW-1:0]        page_off;
  logic [CW-1:0]        prog_cnt;
  logic [PW:0]          page_len;
  logic                 write_guard_s1;
  logic                 write_guard_s2;
  logic                 opcode_fresh;
  logic                 guard_init;
  logic                 tx_live;

  wire [7:0] next_byte = {shift_in[6:0], din_s};
  wire       byte_done = sck_rise && (bit_cnt == 3'd7);
  wire [7:0] status_byte = {SPEEP_ST_TOP_ONES, guard_level, permit, busy};

  // Opcode decode, X bit ignored where it carries address
  wire [7:0] op_core = next_byte & SPEEP_OP_XBIT_MASK;
  wire is_set   = next_byte == SPEEP_OP_SET_PERMIT;
  wire is_clr   = next_byte == SPEEP_OP_CLEAR_PERMIT;
  wire is_rdst  = next_byte == SPEEP_OP_READ_STATUS;
  wire is_wrst  = next_byte == SPEEP_OP_WRITE_STATUS;
  wire is_read  = op_core == SPEEP_OP_READ_MEM;
  wire is_write = op_core == SPEEP_OP_WRITE_MEM;
  wire hi_addr  = (ADDR_BITS > 8) && next_byte[SPEEP_OP_XBIT_POS];
  wire writable = write_guard_s2 && permit;

  // Write guard also sampled; it gates writes up to the closing edge
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      write_guard_s1 <= 1'b0;
      write_guard_s2 <= 1'b0;
    end
    else
    begin
      write_guard_s1 <= write_guard_b;
      write_guard_s2 <= write_guard_s1;
    end
  end

  // Protected range: top quarter, upper half, or all
  function automatic logic guarded(input logic [1:0] lvl, input logic [ADDR_BITS-1:0] a);
    case (lvl)
      2'b01:   guarded = &a[ADDR_BITS-1 -: 2];
      2'b10:   guarded = a[ADDR_BITS-1];
      2'b11:   guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  endfunction : guarded

  // ----------------------------------------------------------------------
  // Page buffer: offset and data travel through the FIFO
  // ----------------------------------------------------------------------
  logic            fifo_in_valid;
  logic            fifo_in_ready;
  logic            fifo_out_valid;
  logic [PW+7:0]   fifo_out_data;
  wire             fifo_drain = busy && fifo_out_valid;
  speep_fifo #(.WIDTH(PW + 8), .DEPTH(FIFO_DEPTH)) u_page (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .flush     (sel_open && !busy),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({page_off, next_byte}),
    .out_valid (fifo_out_valid),
    .out_ready (busy),
    .out_data  (fifo_out_data)
  );
  assign fifo_in_valid = byte_done && phase == SPEEP_PH_WDATA && page_len < (PW+1)'(FIFO_DEPTH);

  // ----------------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || sel_s)
    begin
      phase   <= SPEEP_PH_OPCODE;
      bit_cnt <= '0;
      shift_in <= '0;
    end
    else if (sck_rise)
    begin
      shift_in <= next_byte;
      bit_cnt  <= bit_cnt + 3'd1;
    end
    if (rst_b && !sel_s && byte_done)
    begin
      case (phase)
        SPEEP_PH_OPCODE:
        begin
          opcode <= next_byte;
          if (is_rdst)
            phase <= SPEEP_PH_STATUS_OUT;
          else if (busy)
            phase <= SPEEP_PH_IGNORE;
          else if (is_read || is_write)
          begin
            addr[ADDR_BITS-1] <= hi_addr;
            phase <= SPEEP_PH_ADDR;
          end
          else if (is_wrst)
            phase <= SPEEP_PH_STATUS_IN;
          else
            phase <= SPEEP_PH_IGNORE;
        end
        SPEEP_PH_ADDR:
        begin
          addr[7:0] <= next_byte;
          phase <= ((opcode & SPEEP_OP_XBIT_MASK) == SPEEP_OP_READ_MEM) ?
                   SPEEP_PH_RDATA : SPEEP_PH_WDATA;
        end
        SPEEP_PH_RDATA:
          addr <= addr + 1'b1;
        default:
          phase <= phase;
      endcase
    end
  end

  // Page write collection, offset wraps inside the page
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || sel_open)
    begin
      page_off <= '0;
      page_len <= '0;
    end
    else if (byte_done && phase == SPEEP_PH_ADDR)
      page_off <= next_byte[PW-1:0];
    else if (fifo_in_valid && fifo_in_ready)
    begin
      page_off <= page_off + 1'b1;
      page_len <= page_len + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Output shifting on falling edges, floats when deselected or paused
  // ----------------------------------------------------------------------
  wire load_tx = byte_done && (phase == SPEEP_PH_ADDR || phase == SPEEP_PH_RDATA ||
                 (phase == SPEEP_PH_OPCODE && is_rdst) || phase == SPEEP_PH_STATUS_OUT);
  wire [7:0] load_val = (phase == SPEEP_PH_ADDR)  ? mem[{addr[ADDR_BITS-1:8], next_byte}] :
                        (phase == SPEEP_PH_RDATA) ? mem[addr + 1'b1] : status_byte;
  // Every falling edge in a sending phase moves out one bit, the first one too
  wire tx_step = sck_fall && (phase == SPEEP_PH_RDATA || phase == SPEEP_PH_STATUS_OUT);
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || sel_s)
    begin
      tx_byte     <= '0;
      data_out    <= 1'b0;
      tx_live     <= 1'b0;
      data_out_oe <= 1'b0;
    end
    else
    begin
      if (load_tx)
        tx_byte <= load_val;
      else if (tx_step)
        tx_byte <= {tx_byte[6:0], 1'b0};
      if (tx_step)
      begin
        data_out <= tx_byte[7];
        tx_live  <= 1'b1;
      end
      // Pause floats the pin; resuming drives the held bit again
      data_out_oe <= pause_s && (tx_live || tx_step);
    end
  end

  // ----------------------------------------------------------------------
  // Latch, protect bits and self-timed programming
  // ----------------------------------------------------------------------
  wire closing_write  = sel_close && !busy && phase == SPEEP_PH_WDATA &&
                        bit_cnt == 3'd0 && page_len != '0 && writable;
  wire closing_status = sel_close && !busy && phase == SPEEP_PH_STATUS_IN &&
                        bit_cnt == 3'd0 && status_pending && writable;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      permit         <= 1'b0;
      guard_level    <= SPEEP_GUARD_RESET;
      busy           <= 1'b0;
      prog_cnt       <= '0;
      status_pending <= 1'b0;
      page_pending   <= 1'b0;
      new_guard      <= '0;
      page_base      <= '0;
    end
    else
    begin
      if (rst_b && guard_init)
        guard_level <= guard_restore;
      if (sel_open)
        status_pending <= 1'b0;
      if (byte_done && phase == SPEEP_PH_STATUS_IN && !status_pending)
      begin
        new_guard      <= next_byte[SPEEP_ST_GUARD_HI_POS:SPEEP_ST_GUARD_LO_POS];
        status_pending <= 1'b1;
      end
      if (sel_close && !busy && bit_cnt == 3'd0 && opcode_fresh)
        permit <= (opcode == SPEEP_OP_SET_PERMIT) ? 1'b1 :
                  (opcode == SPEEP_OP_CLEAR_PERMIT) ? 1'b0 : permit;
      if (closing_write || closing_status)
      begin
        busy         <= 1'b1;
        prog_cnt     <= CW'(WRITE_CYCLES);
        page_pending <= closing_write;
        page_base    <= {addr[ADDR_BITS-1:PW], {PW{1'b0}}};
        permit       <= 1'b0;
      end
      else if (busy)
      begin
        prog_cnt <= prog_cnt - 1'b1;
        if (prog_cnt == CW'(1))
        begin
          busy <= 1'b0;
          if (!page_pending)
            guard_level <= new_guard;
        end
      end
    end
  end

  // Opcode was completed and no further bits followed it
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      opcode_fresh <= 1'b0;
      guard_init   <= 1'b1;
    end
    else
    begin
      guard_init <= 1'b0;
      if (sel_open || sck_rise)
        opcode_fresh <= 1'b0;
      if (byte_done && phase == SPEEP_PH_OPCODE && !busy && (is_set || is_clr))
        opcode_fresh <= 1'b1;
    end
  end

  // Array programming drains the page buffer, skipping protected bytes
  wire [ADDR_BITS-1:0] prog_addr = page_base | ADDR_BITS'(fifo_out_data[PW+7:8]);
  always_ff @(posedge core_clk)
  begin
    if (fifo_drain && !guarded(guard_level, prog_addr))
      mem[prog_addr] <= fifo_out_data[7:0];
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence closing_s;
    closing_write || closing_status;
  endsequence
  float_idle_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    sel_s |=> !data_out_oe)
    else $error("data-out driven while deselected");
  busy_start_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    closing_s |=> busy && !permit)
    else $error("programming did not start or latch kept");
  guard_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (sel_close && !write_guard_s2) |=> !$rose(busy))
    else $error("write started with guard low");
  status_fmt_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (load_tx && phase == SPEEP_PH_OPCODE) |=>
      tx_byte == {SPEEP_ST_TOP_ONES, $past(guard_level), $past(permit), $past(busy)})
    else $error("status byte malformed");
  busy_ignore_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (busy && byte_done && phase == SPEEP_PH_OPCODE && !is_rdst)
      |=> phase == SPEEP_PH_IGNORE)
    else $error("command obeyed while busy");
  guard_stable_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!busy && !guard_init) |=> $stable(guard_level))
    else $error("protect bits changed outside status write");
endmodule : speep_top
`default_nettype wire

// >>> dv/speep_host.sv
// Host controller model: frames pin traffic MSB first on an 80 ns shift clock.
// Assumes core_clk paces it; the shift clock stands still between frames.
`timescale 1ns/1ps
`default_nettype none
module speep_host
  import speep_pkg::*;
(
  // Clock
  input  wire logic core_clk,
  // Toward the device
  output logic      select_b,
  output logic      shift_clk,
  output logic      data_in,
  output logic      pause_b,
  // From the device
  input  wire logic data_out
);
  int   pause_bit = -1;
  logic idle_clk  = 1'b0;
  // Deselected at time zero
  initial
  begin
    select_b  = 1'b1;
    shift_clk = 1'b0;
    data_in   = 1'b0;
    pause_b   = 1'b1;
  end
  // One frame; rx holds data-out sampled just before each rise
  task automatic frame(input logic [159:0] tx, input int n, output logic [159:0] rx);
    rx = '0;
    @(posedge core_clk);
    shift_clk <= idle_clk;
    repeat (10) @(posedge core_clk);
    select_b <= 1'b0;
    repeat (10) @(posedge core_clk);
    for (int i = n - 1; i >= 0; i--)
    begin
      shift_clk <= 1'b0;
      data_in   <= tx[i];
      repeat (10) @(posedge core_clk);
      if (i == pause_bit)
      begin
        pause_b <= 1'b0;
        repeat (30) @(posedge core_clk);
        pause_b <= 1'b1;
        repeat (10) @(posedge core_clk);
      end
      rx[i] = data_out;
      shift_clk <= 1'b1;
      repeat (10) @(posedge core_clk);
    end
    shift_clk <= idle_clk;
    repeat (10) @(posedge core_clk);
    select_b <= 1'b1;
    data_in  <= ~data_in;
    repeat (10) @(posedge core_clk);
  endtask : frame
endmodule : speep_host
`default_nettype wire

// >>> dv/speep_top_tb_top.sv
// Self-checking bench for the serial memory command port.
// Assumes the host model drives the link; programming time is shortened.
`timescale 1ns/1ps
`default_nettype none
module speep_top_tb_top
  import speep_pkg::*;
;
  localparam int         WCYC    = 2000;
  localparam logic [8:0] HIT_A [3] = '{9'h1F0, 9'h17F, 9'h0FF};
  localparam logic [7:0] HIT_D [3] = '{8'hA3, 8'h61, 8'h62};
  localparam logic [8:0] OPN_A [3] = '{9'h17F, 9'h0FF, 9'h000};
  localparam logic [7:0] OPN_D [3] = '{8'h61, 8'h62, 8'h5C};
  logic       core_clk      = 1'b0;
  logic       rst_b         = 1'b0;
  logic       write_guard_b = 1'b1;
  logic [1:0] guard_restore = 2'h2;
  wire logic  select_b, shift_clk, data_in, pause_b, data_out, data_out_oe, busy;
  wire logic [1:0] guard_level;
  logic [159:0] rx;
  int n_errors = 0, comparisons = 0, cycles = 0, oe_cycles = 0;
  // 250 MHz clock
  always #2 core_clk = ~core_clk;
  // Count driven cycles; cut a hang short
  always @(posedge core_clk)
  begin
    oe_cycles += data_out_oe;
    cycles++;
    if (cycles == 95000)
    begin
      n_errors++;
      close_out();
    end
  end
  speep_top #(.ADDR_BITS(9), .WRITE_CYCLES(WCYC), .FIFO_DEPTH(16)) speep_top_i (
    .core_clk(core_clk), .rst_b(rst_b), .select_b(select_b), .shift_clk(shift_clk),
    .data_in(data_in), .pause_b(pause_b), .write_guard_b(write_guard_b),
    .data_out(data_out), .data_out_oe(data_out_oe), .guard_restore(guard_restore),
    .guard_level(guard_level), .busy(busy));
  // A floating data-out line reads as the inverse of its last value
  speep_host speep_host_i (.core_clk(core_clk), .select_b(select_b), .shift_clk(shift_clk),
    .data_in(data_in), .pause_b(pause_b), .data_out(data_out_oe ? data_out : ~data_out));
  // Compare one byte
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] op);
    speep_host_i.frame({152'h0, op}, 8, rx);
  endtask : cmd
  task automatic status(input logic [7:0] exp);
    speep_host_i.frame({144'h0, SPEEP_OP_READ_STATUS, 8'h00}, 16, rx);
    chk("status", exp, rx[7:0]);
    chk("oe idle", 8'h00, {7'h0, data_out_oe});
  endtask : status
  // Bounded wait for programming to end
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < WCYC + 100)
    begin
      @(posedge core_clk);
      k++;
    end
    chk("busy", 8'h00, {7'h0, busy});
  endtask : wait_idle
  task automatic write_status_cmd(input logic [7:0] v);
    cmd(SPEEP_OP_SET_PERMIT);
    speep_host_i.frame({144'h0, SPEEP_OP_WRITE_STATUS, v}, 16, rx);
  endtask : write_status_cmd
  task automatic wr(input logic [8:0] a, input int nb, input logic [127:0] d, input bit en);
    logic [159:0] tx;
    if (en)
      cmd(SPEEP_OP_SET_PERMIT);
    tx = {144'h0, SPEEP_OP_WRITE_MEM | {4'h0, a[8], 3'h0}, a[7:0]};
    speep_host_i.frame((tx << (8 * nb)) | {32'h0, d}, 16 + 8 * nb, rx);
  endtask : wr
  task automatic rd(input logic [8:0] a, input int nb);
    speep_host_i.frame({144'h0, SPEEP_OP_READ_MEM | {4'h0, a[8], 3'h0}, a[7:0]} << (8 * nb),
      16 + 8 * nb, rx);
  endtask : rd
  // Restored guard bits in both clock modes
  task automatic sc_reset();
    chk("guard", 8'h02, {6'h0, guard_level});
    status(8'hF8);
    speep_host_i.idle_clk = 1'b1;
    status(8'hF8);
    speep_host_i.idle_clk = 1'b0;
  endtask : sc_reset
  // Latch opcodes, a near-miss opcode, a cut-short opcode
  task automatic sc_opcodes();
    cmd(SPEEP_OP_SET_PERMIT);
    status(8'hFA);
    cmd(8'h14);
    status(8'hFA);
    cmd(SPEEP_OP_CLEAR_PERMIT);
    status(8'hF8);
    cmd(SPEEP_OP_SET_PERMIT);
    speep_host_i.frame({153'h0, 7'h02}, 7, rx);
    status(8'hFA);
  endtask : sc_opcodes
  // Status write tries the read-only bits too
  task automatic sc_status_write();
    write_status_cmd(8'h03);
    chk("busy up", 8'h01, {7'h0, busy});
    wait_idle();
    status(8'hF0);
    chk("guard", 8'h00, {6'h0, guard_level});
  endtask : sc_status_write
  // Page roll, commands while busy, read wrap with a pause
  task automatic sc_page();
    int k;
    wr(9'h1FE, 3, 128'hA1_A2A3, 1);
    k = oe_cycles;
    rd(9'h1FE, 1);
    chk("ignored", 8'h00, 8'(oe_cycles - k));
    speep_host_i.frame({144'h0, SPEEP_OP_READ_STATUS, 8'h00}, 16, rx);
    chk("busy bit", 8'h01, {7'h0, rx[0]});
    wait_idle();
    status(8'hF0);
    wr(9'h000, 1, 128'h5C, 1);
    wait_idle();
    speep_host_i.pause_bit = 9;
    rd(9'h1FF, 2);
    speep_host_i.pause_bit = -1;
    chk("wrap top", 8'hA2, rx[15:8]);
    chk("wrap low", 8'h5C, rx[7:0]);
    rd(9'h1F0, 1);
    chk("page roll", 8'hA3, rx[7:0]);
  endtask : sc_page
  // Writes without the latch and with the guard pin low
  task automatic sc_refuse();
    wr(9'h000, 1, 128'h11, 0);
    wait_idle();
    write_guard_b <= 1'b0;
    wr(9'h000, 1, 128'h22, 1);
    wait_idle();
    write_guard_b <= 1'b1;
    rd(9'h000, 1);
    chk("refused", 8'h5C, rx[7:0]);
  endtask : sc_refuse
  // Guard levels 1 and 2: one open and one guarded address each; at level 3 both addresses are guarded
  task automatic sc_protect();
    for (int g = 1; g <= 3; g++)
    begin
      write_status_cmd(8'(g << 2));
      wait_idle();
      chk("guard", 8'(g), {6'h0, guard_level});
      wr(OPN_A[g - 1], 1, 128'(8'h60 + g), 1);
      wait_idle();
      wr(HIT_A[g - 1], 1, 128'h99, 1);
      wait_idle();
      rd(OPN_A[g - 1], 1);
      chk("open", OPN_D[g - 1], rx[7:0]);
      rd(HIT_A[g - 1], 1);
      chk("guarded", HIT_D[g - 1], rx[7:0]);
    end
  endtask : sc_protect
  task automatic close_out();
    $display("Comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  // Main sequence
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge core_clk);
    sc_reset();
    sc_opcodes();
    sc_status_write();
    sc_page();
    sc_refuse();
    sc_protect();
    close_out();
  end
endmodule : speep_top_tb_top
`default_nettype wire
